//--- sal_pkg.sv
// Purpose: Shared constants and types for the reference-alignment and link configuration bank
// Assumes: Byte-wide registers at their printed offsets on a plain 12-bit address port
// Notes: Status offsets 1F0h..1F2h hold the block's own state and sticky flags
package sal_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int MODE_W = 6;
  localparam int STREAM_W = 4;
  localparam int LANE_W = 5;
  localparam int MAX_LANES = 16;
  localparam int EVCNT_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_REALIGN = 12'h0A0;
  localparam logic [ADDR_W-1:0] OFS_TERM = 12'h0A1;
  localparam logic [ADDR_W-1:0] OFS_LINK_EN = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_MODE = 12'h101;
  localparam logic [ADDR_W-1:0] OFS_STREAMS = 12'h102;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h1F0;
  localparam logic [ADDR_W-1:0] OFS_EVCOUNT = 12'h1F1;
  localparam logic [ADDR_W-1:0] OFS_LANES = 12'h1F2;

  // Reset values
  localparam logic [DATA_W-1:0] RST_REALIGN = 8'h00;
  localparam logic [DATA_W-1:0] RST_TERM = 8'h00;
  localparam logic [DATA_W-1:0] RST_LINK_EN = 8'h00;
  localparam logic [DATA_W-1:0] RST_MODE = 8'h00;
  localparam logic [DATA_W-1:0] RST_STREAMS = 8'h01;
  localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;
  localparam logic [EVCNT_W-1:0] EVCNT_ZERO = 8'h00;
  localparam logic [EVCNT_W-1:0] EVCNT_ONE = 8'h01;
  localparam logic [EVCNT_W-1:0] EVCNT_MAX = 8'hFF;

  // Field positions
  localparam int BIT_REALIGN_EN = 0;
  localparam int BIT_TERM_SE = 0;
  localparam int BIT_LINK_EN = 0;
  localparam int MODE_LSB = 0;
  localparam int STREAM_LSB = 0;

  // Status register bits
  localparam int STS_LINK_EN_MISUSE = 0;
  localparam int STS_CFG_MISUSE = 1;
  localparam int STS_LINK_ACTIVE = 2;
  localparam int STS_REALIGN_ON = 3;

  typedef struct packed {
    logic [STREAM_W-1:0] max_streams;
    logic [LANE_W-1:0] lane_count;
  } sal_mode_info_type;

  typedef struct packed {
    logic realign_enable;
    logic term_single_ended;
    logic link_rst_n;
    logic phy_enable;
    logic lmfc_rst_n;
    logic [MODE_W-1:0] mode;
    logic [STREAM_W-1:0] streams;
  } sal_link_ctl_type;

  typedef struct packed {
    logic divider_realign;
    logic link_realign;
    logic lmfc_realign;
  } sal_realign_type;

endpackage

//--- sal_lane_calc.sv
// Purpose: Works out how many serial lanes to enable and drives the per-lane enables
// Assumes: Mode maximum stream count and lane count arrive from the mode lookup
// Notes: Result is registered; a zero mode maximum enables no lanes
`timescale 1ns/1ps
module sal_lane_calc #(
  parameter int MAX_LANES = sal_pkg::MAX_LANES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_on,
  input wire logic [sal_pkg::STREAM_W-1:0] streams,
  input wire sal_pkg::sal_mode_info_type mode_info,
  output logic [sal_pkg::LANE_W-1:0] lane_total,
  output logic [MAX_LANES-1:0] lane_enable
);

  localparam logic [sal_pkg::LANE_W-1:0] LANE_CAP = sal_pkg::LANE_W'(MAX_LANES);
  localparam logic [sal_pkg::LANE_W-1:0] LANE_NONE = 5'h00;

  logic [sal_pkg::LANE_W-1:0] lane_total_reg;
  logic [sal_pkg::LANE_W-1:0] lane_total_next;
  logic [MAX_LANES-1:0] lane_enable_reg;
  logic [MAX_LANES-1:0] lane_enable_next;
  wire logic [sal_pkg::LANE_W-1:0] stream_sum;
  wire logic [sal_pkg::LANE_W-1:0] group_count;
  wire logic [2*sal_pkg::LANE_W-1:0] lane_product;

  // Ceiling of streams over the mode maximum, times the lanes per group
  assign stream_sum = sal_pkg::LANE_W'({1'b0, streams} + {1'b0, mode_info.max_streams} - 5'h01);
  assign group_count = (mode_info.max_streams == 4'h0) ? LANE_NONE :
                       sal_pkg::LANE_W'(stream_sum / {1'b0, mode_info.max_streams});
  assign lane_product = group_count * mode_info.lane_count;
  assign lane_total_next = !link_on ? LANE_NONE :
                           (lane_product > {5'h00, LANE_CAP}) ? LANE_CAP :
                           lane_product[sal_pkg::LANE_W-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < MAX_LANES; gi++) begin : g_lane
      assign lane_enable_next[gi] = (sal_pkg::LANE_W'(gi) < lane_total_next);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lane_total_reg <= LANE_NONE;
      lane_enable_reg <= '0;
    end else begin
      lane_total_reg <= lane_total_next;
      lane_enable_reg <= lane_enable_next;
    end
  end

  assign lane_total = lane_total_reg;
  assign lane_enable = lane_enable_reg;

endmodule

//--- sal_config_bank.sv
// Purpose: Configuration bank for reference-edge realignment, reference termination,
//   serial link enable, link mode and sample stream count
// Assumes: Plain register port, read data valid the cycle after the read strobe;
//   the reference input and datapath enable are synchronous to clk
// Notes: Reserved bits are stored and read back but steer nothing
// Notes on behaviour
// - With the realignment enable set, every detected reference edge realigns the divider, and the link subsystem too if the link is on; otherwise none does.
// - The termination select bit picks 100 ohm differential at 0 and 50 ohm single-ended to ground at 1.
// - A set link enable activates the serial interface, a clear one holds the link subsystem in reset and the PHY off.
// - With the link disabled the multiframe counter is held in reset so reference edges do not align it.
// - A six-bit link mode field sits in the low bits of its register and resets to zero.
// - A four-bit stream count field sits in bits 3 to 0 and resets to one.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module sal_config_bank #(
  parameter int MAX_LANES = sal_pkg::MAX_LANES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [sal_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sal_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sal_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sysref_in,
  input wire logic datapath_enable,
  input wire sal_pkg::sal_mode_info_type mode_info,
  output sal_pkg::sal_link_ctl_type link_ctl,
  output sal_pkg::sal_realign_type realign,
  output logic [sal_pkg::LANE_W-1:0] lane_total,
  output logic [MAX_LANES-1:0] lane_enable
);

  // Stored registers
  logic [sal_pkg::DATA_W-1:0] realign_ctrl_reg;
  logic [sal_pkg::DATA_W-1:0] realign_ctrl_next;
  logic [sal_pkg::DATA_W-1:0] term_cfg_reg;
  logic [sal_pkg::DATA_W-1:0] term_cfg_next;
  logic [sal_pkg::DATA_W-1:0] link_en_reg;
  logic [sal_pkg::DATA_W-1:0] link_en_next;
  logic [sal_pkg::DATA_W-1:0] mode_reg;
  logic [sal_pkg::DATA_W-1:0] mode_next;
  logic [sal_pkg::DATA_W-1:0] streams_reg;
  logic [sal_pkg::DATA_W-1:0] streams_next;
  logic [sal_pkg::DATA_W-1:0] rdata_reg;
  logic [sal_pkg::DATA_W-1:0] rdata_next;

  // Own state
  logic sysref_prev_reg;
  logic link_misuse_reg;
  logic link_misuse_next;
  logic cfg_misuse_reg;
  logic cfg_misuse_next;
  logic [sal_pkg::EVCNT_W-1:0] evcount_reg;
  logic [sal_pkg::EVCNT_W-1:0] evcount_next;
  sal_pkg::sal_realign_type realign_reg;
  sal_pkg::sal_realign_type realign_next;
  sal_pkg::sal_link_ctl_type link_ctl_reg;
  sal_pkg::sal_link_ctl_type link_ctl_next;

  // Address decode
  wire logic hit_realign;
  wire logic hit_term;
  wire logic hit_link_en;
  wire logic hit_mode;
  wire logic hit_streams;
  wire logic hit_status;
  wire logic hit_evcount;
  wire logic hit_lanes;

  assign hit_realign = (reg_addr == sal_pkg::OFS_REALIGN);
  assign hit_term = (reg_addr == sal_pkg::OFS_TERM);
  assign hit_link_en = (reg_addr == sal_pkg::OFS_LINK_EN);
  assign hit_mode = (reg_addr == sal_pkg::OFS_MODE);
  assign hit_streams = (reg_addr == sal_pkg::OFS_STREAMS);
  assign hit_status = (reg_addr == sal_pkg::OFS_STATUS);
  assign hit_evcount = (reg_addr == sal_pkg::OFS_EVCOUNT);
  assign hit_lanes = (reg_addr == sal_pkg::OFS_LANES);

  wire logic wr_realign;
  wire logic wr_term;
  wire logic wr_link_en;
  wire logic wr_mode;
  wire logic wr_streams;
  wire logic wr_status;
  wire logic wr_evcount;

  assign wr_realign = reg_wr && hit_realign;
  assign wr_term = reg_wr && hit_term;
  assign wr_link_en = reg_wr && hit_link_en;
  assign wr_mode = reg_wr && hit_mode;
  assign wr_streams = reg_wr && hit_streams;
  assign wr_status = reg_wr && hit_status;
  assign wr_evcount = reg_wr && hit_evcount;

  // Only the documented field bits steer anything
  wire logic realign_en;
  wire logic term_se;
  wire logic link_on;
  wire logic [sal_pkg::MODE_W-1:0] mode_field;
  wire logic [sal_pkg::STREAM_W-1:0] stream_field;

  assign realign_en = realign_ctrl_reg[sal_pkg::BIT_REALIGN_EN];
  assign term_se = term_cfg_reg[sal_pkg::BIT_TERM_SE];
  assign link_on = link_en_reg[sal_pkg::BIT_LINK_EN];
  assign mode_field = mode_reg[sal_pkg::MODE_LSB +: sal_pkg::MODE_W];
  assign stream_field = streams_reg[sal_pkg::STREAM_LSB +: sal_pkg::STREAM_W];

  // Register writes; whole bytes are kept so reserved bits read back as written
  assign realign_ctrl_next = wr_realign ? reg_wdata : realign_ctrl_reg;
  assign term_cfg_next = wr_term ? reg_wdata : term_cfg_reg;
  assign link_en_next = wr_link_en ? reg_wdata : link_en_reg;
  assign mode_next = wr_mode ? reg_wdata : mode_reg;
  assign streams_next = wr_streams ? reg_wdata : streams_reg;

  // Reference edge detection and realignment pulses
  wire logic sysref_edge;
  wire logic link_en_change;
  wire logic cfg_change;

  assign sysref_edge = sysref_in && !sysref_prev_reg;
  assign realign_next.divider_realign = sysref_edge && realign_en;
  assign realign_next.link_realign = sysref_edge && realign_en && link_on;
  assign realign_next.lmfc_realign = sysref_edge && realign_en && link_on;

  // Saturating count of realignment events, cleared by a write of any value to its own offset
  assign evcount_next = wr_evcount ? sal_pkg::EVCNT_ZERO :
                        (realign_next.divider_realign && evcount_reg != sal_pkg::EVCNT_MAX) ?
                        evcount_reg + sal_pkg::EVCNT_ONE : evcount_reg;

  // Sticky flags for out-of-order programming; a new event beats a clear
  assign link_en_change = wr_link_en &&
                          (reg_wdata[sal_pkg::BIT_LINK_EN] != link_on) &&
                          datapath_enable;
  assign cfg_change = (wr_mode || wr_streams) && link_on;
  assign link_misuse_next = link_en_change ? 1'b1 :
                            (wr_status && reg_wdata[sal_pkg::STS_LINK_EN_MISUSE]) ? 1'b0 :
                            link_misuse_reg;
  assign cfg_misuse_next = cfg_change ? 1'b1 :
                           (wr_status && reg_wdata[sal_pkg::STS_CFG_MISUSE]) ? 1'b0 :
                           cfg_misuse_reg;

  // Control outputs are registered from the next field values, so they change in the same cycle as the stored fields
  wire logic next_link_on;
  assign next_link_on = link_en_next[sal_pkg::BIT_LINK_EN];
  assign link_ctl_next.realign_enable = realign_ctrl_next[sal_pkg::BIT_REALIGN_EN];
  assign link_ctl_next.term_single_ended = term_cfg_next[sal_pkg::BIT_TERM_SE];
  assign link_ctl_next.link_rst_n = next_link_on;
  assign link_ctl_next.phy_enable = next_link_on;
  assign link_ctl_next.lmfc_rst_n = next_link_on;
  assign link_ctl_next.mode = mode_next[sal_pkg::MODE_LSB +: sal_pkg::MODE_W];
  assign link_ctl_next.streams = streams_next[sal_pkg::STREAM_LSB +: sal_pkg::STREAM_W];

  // Status view of the block's own state
  wire logic [sal_pkg::DATA_W-1:0] status_view;
  wire logic [sal_pkg::DATA_W-1:0] lanes_view;
  assign status_view = {4'h0, realign_en, link_on, cfg_misuse_reg, link_misuse_reg};
  assign lanes_view = sal_pkg::DATA_W'(lane_total);

  // Read mux; unmapped addresses read zero
  assign rdata_next = !reg_rd ? sal_pkg::RD_ZERO :
                      hit_realign ? realign_ctrl_reg :
                      hit_term ? term_cfg_reg :
                      hit_link_en ? link_en_reg :
                      hit_mode ? mode_reg :
                      hit_streams ? streams_reg :
                      hit_status ? status_view :
                      hit_evcount ? evcount_reg :
                      hit_lanes ? lanes_view :
                      sal_pkg::RD_ZERO;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      realign_ctrl_reg <= sal_pkg::RST_REALIGN;
      term_cfg_reg <= sal_pkg::RST_TERM;
      link_en_reg <= sal_pkg::RST_LINK_EN;
      mode_reg <= sal_pkg::RST_MODE;
      streams_reg <= sal_pkg::RST_STREAMS;
    end else begin
      realign_ctrl_reg <= realign_ctrl_next;
      term_cfg_reg <= term_cfg_next;
      link_en_reg <= link_en_next;
      mode_reg <= mode_next;
      streams_reg <= streams_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sysref_prev_reg <= 1'b0;
      link_misuse_reg <= 1'b0;
      cfg_misuse_reg <= 1'b0;
      evcount_reg <= sal_pkg::EVCNT_ZERO;
      rdata_reg <= sal_pkg::RD_ZERO;
    end else begin
      sysref_prev_reg <= sysref_in;
      link_misuse_reg <= link_misuse_next;
      cfg_misuse_reg <= cfg_misuse_next;
      evcount_reg <= evcount_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      realign_reg <= '0;
      link_ctl_reg <= '{realign_enable: 1'b0, term_single_ended: 1'b0,
                        link_rst_n: 1'b0, phy_enable: 1'b0, lmfc_rst_n: 1'b0,
                        mode: sal_pkg::RST_MODE[sal_pkg::MODE_W-1:0],
                        streams: sal_pkg::RST_STREAMS[sal_pkg::STREAM_W-1:0]};
    end else begin
      realign_reg <= realign_next;
      link_ctl_reg <= link_ctl_next;
    end
  end

  sal_lane_calc #(
    .MAX_LANES(MAX_LANES)
  ) u_lane_calc (
    .clk(clk),
    .nrst(nrst),
    .link_on(link_on),
    .streams(stream_field),
    .mode_info(mode_info),
    .lane_total(lane_total),
    .lane_enable(lane_enable)
  );

  assign reg_rdata = rdata_reg;
  assign link_ctl = link_ctl_reg;
  assign realign = realign_reg;

endmodule

//--- sal_tx_model.sv
// Purpose: Far-end transmitter model giving reference pulses and mode table data
// Assumes: Mode table contents are arbitrary stand-ins for the real lookup
// Notes: Reference stays high two cycles, so a low sample always separates edges
`timescale 1ns/1ps
module sal_tx_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic fire,
  input wire logic [sal_pkg::MODE_W-1:0] mode,
  output logic sysref_out,
  output sal_pkg::sal_mode_info_type mode_info
);
  logic [1:0] hold_reg;
  assign mode_info.max_streams = 4'h1 << mode[1:0];
  assign mode_info.lane_count = {2'h0, mode[4:2]} + 5'h01;
  assign sysref_out = |hold_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_reg <= 2'h0;
    end else begin
      hold_reg <= {hold_reg[0], fire};
    end
  end
endmodule

//--- sal_config_monitor.sv
// Purpose: Concurrent checks on the configuration bank ports
// Assumes: One clock domain, synchronous active-low reset
// Notes: Lane count is compared only while its inputs are steady
`timescale 1ns/1ps
module sal_config_monitor #(
  parameter int MAX_LANES = sal_pkg::MAX_LANES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [sal_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sal_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [sal_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sysref_in,
  input wire logic datapath_enable,
  input wire sal_pkg::sal_mode_info_type mode_info,
  input wire sal_pkg::sal_link_ctl_type link_ctl,
  input wire sal_pkg::sal_realign_type realign,
  input wire logic [sal_pkg::LANE_W-1:0] lane_total,
  input wire logic [MAX_LANES-1:0] lane_enable
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  int lane_calc;
  always_comb begin
    lane_calc = 0;
    if (link_ctl.link_rst_n && mode_info.max_streams != 4'h0) begin
      lane_calc = ((int'(link_ctl.streams) + int'(mode_info.max_streams) - 1)
        / int'(mode_info.max_streams)) * int'(mode_info.lane_count);
    end
    if (lane_calc > MAX_LANES) begin
      lane_calc = MAX_LANES;
    end
  end
  sequence ref_rise_s;
    $rose(sysref_in);
  endsequence
  sequence steady_s;
    $stable(link_ctl) && $stable(mode_info);
  endsequence
  div_pulse_a: assert property (ref_rise_s ##0 link_ctl.realign_enable
    |=> realign.divider_realign) else $error("divider realign missing");
  div_quiet_a: assert property (realign.divider_realign |-> $past(link_ctl.realign_enable)
    && $past(sysref_in) && !$past(sysref_in, 2)) else $error("divider realign unexpected");
  link_pulse_a: assert property (ref_rise_s ##0 (link_ctl.realign_enable
    && link_ctl.link_rst_n) |=> realign.link_realign && realign.lmfc_realign)
    else $error("link realign missing");
  lmfc_gate_a: assert property ((realign.link_realign || realign.lmfc_realign)
    |-> $past(link_ctl.lmfc_rst_n) && realign.divider_realign) else $error("link realign gated");
  term_sel_a: assert property (reg_wr && reg_addr == sal_pkg::OFS_TERM
    |=> link_ctl.term_single_ended == $past(reg_wdata[0])) else $error("termination wrong");
  link_en_a: assert property (reg_wr && reg_addr == sal_pkg::OFS_LINK_EN
    |=> link_ctl.link_rst_n == $past(reg_wdata[0]) && link_ctl.phy_enable == $past(reg_wdata[0]))
    else $error("link enable wrong");
  lmfc_hold_a: assert property (!link_ctl.link_rst_n
    |-> !link_ctl.lmfc_rst_n && !link_ctl.phy_enable) else $error("held parts released");
  mode_wr_a: assert property (reg_wr && reg_addr == sal_pkg::OFS_MODE
    |=> link_ctl.mode == $past(reg_wdata[5:0])) else $error("mode field wrong");
  streams_wr_a: assert property (reg_wr && reg_addr == sal_pkg::OFS_STREAMS
    |=> link_ctl.streams == $past(reg_wdata[3:0])) else $error("stream field wrong");
  lane_total_a: assert property (steady_s |-> lane_total == lane_calc[4:0])
    else $error("lane total wrong");
  lane_mask_a: assert property (lane_enable
    == ({MAX_LANES{1'b1}} >> (MAX_LANES - int'(lane_total)))) else $error("lane mask wrong");
endmodule
bind sal_config_bank sal_config_monitor #(.MAX_LANES(MAX_LANES)) i_mon (.clk(clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sysref_in(sysref_in), .datapath_enable(datapath_enable),
  .mode_info(mode_info), .link_ctl(link_ctl), .realign(realign), .lane_total(lane_total),
  .lane_enable(lane_enable));

//--- sysref_realign_ctrl_link_config_bench.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: Transmitter model supplies reference edges and mode data
// Notes: Link enable moves with the datapath off and mode and streams with link off, except in the misuse checks
`timescale 1ns/1ps
module sysref_realign_ctrl_link_config_bench;
  logic clk, nrst, reg_wr, reg_rd, datapath_enable, fire, sysref_in;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, r;
  sal_pkg::sal_mode_info_type mode_info;
  sal_pkg::sal_link_ctl_type link_ctl;
  sal_pkg::sal_realign_type realign;
  logic [4:0] lane_total;
  logic [15:0] lane_enable;
  logic [3:0] s, np, nl;
  logic [5:0] m;
  logic [11:0] ofs [6] = '{12'h0A0, 12'h0A1, 12'h100, 12'h101, 12'h102, 12'h0A2};
  logic [7:0] v [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [3:0] sv [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
  int fail_count = 0, num_checks = 0, seed = 94382, i, j;
  sal_config_bank #(.MAX_LANES(16)) i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sysref_in(sysref_in), .datapath_enable(datapath_enable), .mode_info(mode_info),
    .link_ctl(link_ctl), .realign(realign), .lane_total(lane_total), .lane_enable(lane_enable));
  sal_tx_model i_tx (.clk(clk), .nrst(nrst), .fire(fire), .mode(link_ctl.mode),
    .sysref_out(sysref_in), .mode_info(mode_info));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] val);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= val;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] val);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    val = reg_rdata;
  endtask
  // Fires one reference pulse and counts realignment pulses that follow
  task automatic ref_edge();
    np = 4'h0;
    nl = 4'h0;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1;
      np = np + realign.divider_realign;
      nl = nl + realign.link_realign + realign.lmfc_realign;
    end
  endtask
  function automatic logic [15:0] lanes_exp(input logic [3:0] sc, input logic [5:0] md);
    int mx, n;
    mx = 1 << md[1:0];
    n = ((sc + mx - 1) / mx) * (md[4:2] + 1);
    return (n > 16) ? 16'h0010 : n[15:0];
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    datapath_enable = 1'b0;
    fire = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(ofs[i], r);
      chk("reset value", {8'h00, v[i]}, {8'h00, r});
    end
    chk("link held", 16'h0, {link_ctl.link_rst_n, link_ctl.phy_enable, link_ctl.lmfc_rst_n});
    for (i = 0; i < 16; i++) begin
      j = (i % 4 == 2) ? 4 : i % 4;
      d = 8'($random(seed));
      if (j == 4) d[3:0] = 4'h2 << (i % 3);
      v[j] = d;
      wr(ofs[j], d);
      rd(ofs[j], r);
      chk("readback", {8'h00, d}, {8'h00, r});
      chk("fields", {4'h0, v[0][0], v[1][0], v[3][5:0], v[4][3:0]}, {4'h0,
        link_ctl.realign_enable, link_ctl.term_single_ended, link_ctl.mode, link_ctl.streams});
    end
    for (i = 0; i < 12; i++) begin
      m = (i == 0) ? 6'h3F : 6'($random(seed));
      s = (i == 0) ? 4'h8 : sv[{$random(seed)} % 5];
      if (s > (4'h1 << m[1:0])) s = 4'h1 << m[1:0];
      datapath_enable <= 1'b0;
      wr(12'h100, 8'hFE);
      wr(12'h101, {2'h0, m});
      wr(12'h102, {4'h0, s});
      d = 8'($random(seed));
      wr(12'h100, d | 8'h01);
      datapath_enable <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("link on", 16'h7, {link_ctl.link_rst_n, link_ctl.phy_enable, link_ctl.lmfc_rst_n});
      chk("lane total", lanes_exp(s, m), {11'h0, lane_total});
      chk("lane enables", (16'h1 << lanes_exp(s, m)) - 16'h1, lane_enable);
    end
    datapath_enable <= 1'b0;
    wr(12'h0A0, 8'hFE);
    ref_edge();
    chk("divider pulses off", 16'h0, {12'h0, np});
    wr(12'h100, 8'h00);
    wr(12'h0A0, 8'h01);
    ref_edge();
    chk("divider pulses", 16'h1, {12'h0, np});
    chk("link pulses off", 16'h0, {12'h0, nl});
    wr(12'h100, 8'h01);
    ref_edge();
    chk("link pulses", 16'h2, {12'h0, nl});
    // Status, event count and lane view of the block's own state
    rd(12'h1F1, r);
    chk("event count", 16'h2, {8'h00, r});
    rd(12'h1F2, r);
    chk("lane view", lanes_exp(s, m), {8'h00, r});
    rd(12'h1F0, r);
    chk("status clean", 16'h0C, {8'h00, r});
    wr(12'h101, {2'h0, m});
    rd(12'h1F0, r);
    chk("config misuse", 16'h0E, {8'h00, r});
    wr(12'h1F0, 8'h02);
    wr(12'h1F1, 8'h5A);
    rd(12'h1F0, r);
    chk("misuse cleared", 16'h0C, {8'h00, r});
    datapath_enable <= 1'b1;
    wr(12'h100, 8'h00);
    rd(12'h1F0, r);
    chk("link misuse", 16'h09, {8'h00, r});
    rd(12'h1F1, r);
    chk("count cleared", 16'h0, {8'h00, r});
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(12'h102, r);
    chk("stream reset", 16'h1, {8'h00, r});
    chk("link reset", 16'h0, {15'h0, link_ctl.link_rst_n});
    complete_run();
  end
endmodule
